// ### verilog/dit_timer.v
// dual 16-bit interval / one-shot timer with square wave output
//
// How it works
// - each timer has 16-bit count and modulo registers and an 8-bit control byte
// - mode bits low: both zero is interval, low one with high zero is one-shot
// - timer 1 control mode bits are hard zero, so it only runs interval
// - interval: writing run one loads count from modulo and starts the countdown
// - interval: at zero the modulo reloads; a period is value plus one ticks
// - timer 1 reloads and counts down the same way from its own registers
// - interval: writing run one again while counting reloads and restarts
// - interval: clearing run halts counting and keeps count and modulo
// - interval count clock is clk/6 when select is zero, clk/128 when one
// - one-shot: count and modulo each count down under their own run bit
// - one-shot: a counter reaching zero stops and holds zero
// - one-shot: count reaching zero clears the timer 0 run bit
// - one-shot: modulo reaching zero clears the modulo run bit
// - one-shot: clearing either run bit freezes its counter
// - one-shot count clocks are clk/12 when select is zero, clk/128 when one
// - interval: modulo clock select and modulo run bit do nothing
// - square enable one: the wave output toggles on every timer 0 flag
// - interval, square enable zero: output sits at the polarity's inactive level
// - one-shot, square enable zero: output asserts on start, returns on flag
// - control registers take byte or bit access with six wait states
// - reset clears both control bytes, stopping timers in interval mode
`timescale 1ns/1ps
`include "dit_defines.vh"

module dit_timer (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire reg_req_i,
    input wire reg_we_i,
    input wire [2:0] reg_addr_i,
    input wire reg_bit_i,
    input wire [3:0] reg_bitpos_i,
    input wire [15:0] reg_wdata_i,
    output reg reg_ack_o,
    output reg [15:0] reg_rdata_o,
    output reg timer_wave_out_o,
    output reg t0_irq_flag_o,
    output reg t1_irq_flag_o,
    output reg modulo0_done_o
);

    localparam BUS_IDLE = 1'b0;
    localparam BUS_WAIT = 1'b1;

    // programmable state
    reg [7:0] t0_ctrl_r;
    reg [7:0] t1_ctrl_r;
    reg [15:0] timer0_count_r;
    reg [15:0] timer0_modulo_r;
    reg [15:0] timer1_count_r;
    reg [15:0] timer1_modulo_r;

    reg [7:0] t0_ctrl_nxt;
    reg [7:0] t1_ctrl_nxt;
    reg [15:0] timer0_count_nxt;
    reg [15:0] timer0_modulo_nxt;
    reg [15:0] timer1_count_nxt;
    reg [15:0] timer1_modulo_nxt;
    reg t0_irq_nxt;
    reg t1_irq_nxt;
    reg m0_done_nxt;
    reg wave_nxt;

    // access port state
    reg bus_state_r;
    reg [`DIT_WAIT_W-1:0] wait_cnt_r;
    reg lat_we_r;
    reg [2:0] lat_addr_r;
    reg lat_bit_r;
    reg [3:0] lat_pos_r;
    reg [15:0] lat_wdata_r;

    wire tick_fast;
    wire tick_mid;
    wire tick_slow;

    dit_prescaler u_prescaler (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_fast_o(tick_fast),
        .tick_mid_o(tick_mid),
        .tick_slow_o(tick_slow)
    );

    // byte write replaces the value, bit write touches one position only
    function [15:0] merge;
        input [15:0] old;
        input [15:0] wdata;
        input bit_acc;
        input [3:0] pos;
        reg [15:0] mask;
        begin
            mask = `DIT_ONE16 << pos;
            if (bit_acc) begin
                merge = wdata[0] ? (old | mask) : (old & ~mask);
            end else begin
                merge = wdata;
            end
        end
    endfunction

    // a run bit is written to one by a byte write or a bit write aimed at it
    function run_set;
        input [15:0] wdata;
        input bit_acc;
        input [3:0] pos;
        input integer field;
        begin
            if (bit_acc) begin
                run_set = wdata[0] && (pos == field);
            end else begin
                run_set = wdata[field];
            end
        end
    endfunction

    // tick for a counter given the mode and its clock select
    function pick_tick;
        input one_shot;
        input sel;
        input fast;
        input mid;
        input slow;
        begin
            if (sel) begin
                pick_tick = slow;
            end else if (one_shot) begin
                pick_tick = mid;
            end else begin
                pick_tick = fast;
            end
        end
    endfunction

    // one-shot needs the low mode bit set and the prohibited high bit clear
    function one_shot_mode;
        input [7:0] ctrl;
        begin
            one_shot_mode = ctrl[`DIT_MODE_LO] && !ctrl[`DIT_MODE_HI];
        end
    endfunction

    function [15:0] read_mux;
        input [2:0] idx;
        begin
            case (idx)
                `DIT_IDX_T0_CTRL: read_mux = {8'h00, t0_ctrl_r};
                `DIT_IDX_T1_CTRL: read_mux = {8'h00, t1_ctrl_r};
                `DIT_IDX_T0_COUNT: read_mux = timer0_count_r;
                `DIT_IDX_T0_MODULO: read_mux = timer0_modulo_r;
                `DIT_IDX_T1_COUNT: read_mux = timer1_count_r;
                `DIT_IDX_T1_MODULO: read_mux = timer1_modulo_r;
                default: read_mux = `DIT_ZERO16;
            endcase
        end
    endfunction

    // access completes after the last wait state
    wire acc_fire = (bus_state_r == BUS_WAIT) && (wait_cnt_r == `DIT_WAIT_STATES - 1);
    wire acc_wr = acc_fire && lat_we_r;
    wire wr_ctrl0 = acc_wr && (lat_addr_r == `DIT_IDX_T0_CTRL);
    wire wr_ctrl1 = acc_wr && (lat_addr_r == `DIT_IDX_T1_CTRL);
    wire wr_cnt0 = acc_wr && (lat_addr_r == `DIT_IDX_T0_COUNT);
    wire wr_mode_sel_lo = acc_wr && (lat_addr_r == `DIT_IDX_T0_MODULO);
    wire wr_cnt1 = acc_wr && (lat_addr_r == `DIT_IDX_T1_COUNT);
    wire wr_mode_sel_hi = acc_wr && (lat_addr_r == `DIT_IDX_T1_MODULO);
    wire [15:0] wr_val = merge(read_mux(lat_addr_r), lat_wdata_r, lat_bit_r, lat_pos_r);

    wire t0_run_wr1 = wr_ctrl0 && run_set(lat_wdata_r, lat_bit_r, lat_pos_r, `DIT_RUN);
    wire t1_run_wr1 = wr_ctrl1 && run_set(lat_wdata_r, lat_bit_r, lat_pos_r, `DIT_RUN);

    // a prohibited high mode bit is treated as interval
    wire t0_one_shot = one_shot_mode(t0_ctrl_r);
    wire t0_tick = pick_tick(t0_one_shot, t0_ctrl_r[`DIT_CLK_SEL],
        tick_fast, tick_mid, tick_slow);
    wire m0_tick = pick_tick(1'b1, t0_ctrl_r[`DIT_M0_CLK_SEL],
        tick_fast, tick_mid, tick_slow);
    wire t1_tick = pick_tick(1'b0, t1_ctrl_r[`DIT_CLK_SEL],
        tick_fast, tick_mid, tick_slow);

    // timer 0 next state
    always @* begin
        t0_ctrl_nxt = t0_ctrl_r;
        timer0_count_nxt = timer0_count_r;
        timer0_modulo_nxt = timer0_modulo_r;
        t0_irq_nxt = 1'b0;
        m0_done_nxt = 1'b0;
        if (!t0_one_shot) begin
            // stopped run bit simply holds both registers
            if (t0_ctrl_r[`DIT_RUN] && t0_tick) begin
                if (timer0_count_r == `DIT_ZERO16) begin
                    timer0_count_nxt = timer0_modulo_r;
                    t0_irq_nxt = 1'b1;
                end else begin
                    timer0_count_nxt = timer0_count_r - `DIT_ONE16;
                end
            end
        end else begin
            if (t0_ctrl_r[`DIT_RUN] && t0_tick) begin
                if (timer0_count_r <= `DIT_ONE16) begin
                    timer0_count_nxt = `DIT_ZERO16;
                    t0_ctrl_nxt[`DIT_RUN] = 1'b0;
                    t0_irq_nxt = 1'b1;
                end else begin
                    timer0_count_nxt = timer0_count_r - `DIT_ONE16;
                end
            end
            // modulo counter only moves in one-shot mode
            if (t0_ctrl_r[`DIT_M0_RUN] && m0_tick) begin
                if (timer0_modulo_r <= `DIT_ONE16) begin
                    timer0_modulo_nxt = `DIT_ZERO16;
                    t0_ctrl_nxt[`DIT_M0_RUN] = 1'b0;
                    m0_done_nxt = 1'b1;
                end else begin
                    timer0_modulo_nxt = timer0_modulo_r - `DIT_ONE16;
                end
            end
        end
        // software writes land after the hardware update so a set beats a clear
        if (wr_ctrl0) begin
            if (lat_bit_r) begin
                t0_ctrl_nxt[lat_pos_r[2:0]] = lat_wdata_r[0];
            end else begin
                t0_ctrl_nxt = lat_wdata_r[7:0];
            end
        end
        if (t0_run_wr1 && !one_shot_mode(t0_ctrl_nxt)) begin
            timer0_count_nxt = timer0_modulo_r;
            t0_irq_nxt = 1'b0;
        end
        if (wr_cnt0) begin
            timer0_count_nxt = wr_val;
        end
        if (wr_mode_sel_lo) begin
            timer0_modulo_nxt = wr_val;
        end
    end

    // timer 1 next state, interval only
    always @* begin
        t1_ctrl_nxt = t1_ctrl_r;
        timer1_count_nxt = timer1_count_r;
        timer1_modulo_nxt = timer1_modulo_r;
        t1_irq_nxt = 1'b0;
        if (t1_ctrl_r[`DIT_RUN] && t1_tick) begin
            if (timer1_count_r == `DIT_ZERO16) begin
                timer1_count_nxt = timer1_modulo_r;
                t1_irq_nxt = 1'b1;
            end else begin
                timer1_count_nxt = timer1_count_r - `DIT_ONE16;
            end
        end
        if (wr_ctrl1) begin
            t1_ctrl_nxt = wr_val[7:0] & `DIT_T1_CTRL_MASK;
        end
        if (t1_run_wr1) begin
            timer1_count_nxt = timer1_modulo_r;
            t1_irq_nxt = 1'b0;
        end
        if (wr_cnt1) begin
            timer1_count_nxt = wr_val;
        end
        if (wr_mode_sel_hi) begin
            timer1_modulo_nxt = wr_val;
        end
    end

    // wave output; the pin mux lives outside the block
    // decided on the new control byte, so a start written together with the mode still asserts
    always @* begin
        wave_nxt = timer_wave_out_o;
        if (t0_ctrl_nxt[`DIT_SQ_EN]) begin
            if (t0_irq_nxt) begin
                wave_nxt = ~timer_wave_out_o;
            end
        end else if (one_shot_mode(t0_ctrl_nxt)) begin
            if (t0_irq_nxt) begin
                wave_nxt = t0_ctrl_nxt[`DIT_POLARITY];
            end else if (t0_run_wr1) begin
                wave_nxt = ~t0_ctrl_nxt[`DIT_POLARITY];
            end
        end else begin
            wave_nxt = t0_ctrl_nxt[`DIT_POLARITY];
        end
    end

    // access port: one request at a time, answered after the wait states
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_state_r <= BUS_IDLE;
            wait_cnt_r <= {`DIT_WAIT_W{1'b0}};
            lat_we_r <= 1'b0;
            lat_addr_r <= 3'h0;
            lat_bit_r <= 1'b0;
            lat_pos_r <= 4'h0;
            lat_wdata_r <= `DIT_ZERO16;
            reg_ack_o <= 1'b0;
            reg_rdata_o <= `DIT_ZERO16;
        end else if (ce_i) begin
            reg_ack_o <= 1'b0;
            case (bus_state_r)
                BUS_IDLE: begin
                    if (reg_req_i) begin
                        bus_state_r <= BUS_WAIT;
                        wait_cnt_r <= {`DIT_WAIT_W{1'b0}};
                        lat_we_r <= reg_we_i;
                        lat_addr_r <= reg_addr_i;
                        lat_bit_r <= reg_bit_i;
                        lat_pos_r <= reg_bitpos_i;
                        lat_wdata_r <= reg_wdata_i;
                    end
                end
                BUS_WAIT: begin
                    if (acc_fire) begin
                        bus_state_r <= BUS_IDLE;
                        reg_ack_o <= 1'b1;
                        if (!lat_we_r) begin
                            // unmapped indexes read as zero
                            reg_rdata_o <= read_mux(lat_addr_r);
                        end
                    end else begin
                        wait_cnt_r <= wait_cnt_r + 1'b1;
                    end
                end
                default: begin
                    bus_state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    // timer state
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            t0_ctrl_r <= `DIT_CTRL_RST;
            t1_ctrl_r <= `DIT_CTRL_RST;
            timer0_count_r <= `DIT_CNT_RST;
            timer0_modulo_r <= `DIT_CNT_RST;
            timer1_count_r <= `DIT_CNT_RST;
            timer1_modulo_r <= `DIT_CNT_RST;
            t0_irq_flag_o <= 1'b0;
            t1_irq_flag_o <= 1'b0;
            modulo0_done_o <= 1'b0;
            timer_wave_out_o <= 1'b0;
        end else if (ce_i) begin
            t0_ctrl_r <= t0_ctrl_nxt;
            t1_ctrl_r <= t1_ctrl_nxt;
            timer0_count_r <= timer0_count_nxt;
            timer0_modulo_r <= timer0_modulo_nxt;
            timer1_count_r <= timer1_count_nxt;
            timer1_modulo_r <= timer1_modulo_nxt;
            t0_irq_flag_o <= t0_irq_nxt;
            t1_irq_flag_o <= t1_irq_nxt;
            modulo0_done_o <= m0_done_nxt;
            timer_wave_out_o <= wave_nxt;
        end
    end

endmodule // dit_timer

// ### verilog/dit_defines.vh
// constants shared by the dual interval / one-shot timer
`ifndef DIT_DEFINES_VH
`define DIT_DEFINES_VH

// register indexes on the access port
`define DIT_IDX_T0_CTRL 3'h0
`define DIT_IDX_T1_CTRL 3'h1
`define DIT_IDX_T0_COUNT 3'h2
`define DIT_IDX_T0_MODULO 3'h3
`define DIT_IDX_T1_COUNT 3'h4
`define DIT_IDX_T1_MODULO 3'h5

// control register fields
`define DIT_MODE_LO 0
`define DIT_MODE_HI 1
`define DIT_POLARITY 2
`define DIT_SQ_EN 3
`define DIT_M0_CLK_SEL 4
`define DIT_M0_RUN 5
`define DIT_CLK_SEL 6
`define DIT_RUN 7

// reset values and writable masks
`define DIT_CTRL_RST 8'h00
`define DIT_CNT_RST 16'h0000
`define DIT_T1_CTRL_MASK 8'hC0
`define DIT_ZERO16 16'h0000
`define DIT_ONE16 16'h0001

// prescale taps
`define DIT_DIV_FAST 6
`define DIT_DIV_MID 12
`define DIT_DIV_SLOW 128
`define DIT_PRE_W 7

// wait states inserted on every register access
`define DIT_WAIT_STATES 6
`define DIT_WAIT_W 3

`endif

// ### verilog/dit_prescaler.v
// free-running prescaler giving one-cycle ticks at clk/6, clk/12 and clk/128
`timescale 1ns/1ps
`include "dit_defines.vh"

module dit_prescaler (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    output reg tick_fast_o,
    output reg tick_mid_o,
    output reg tick_slow_o
);

    reg [`DIT_PRE_W-1:0] fast_cnt_r;
    reg [`DIT_PRE_W-1:0] mid_cnt_r;
    reg [`DIT_PRE_W-1:0] slow_cnt_r;

    // wraps a counter at its divisor and reports the wrap
    function wrap;
        input [`DIT_PRE_W-1:0] cnt;
        input integer div;
        begin
            wrap = (cnt == div - 1);
        end
    endfunction

    // taps run free so a timer start has up to one tick of phase jitter
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_cnt_r <= {`DIT_PRE_W{1'b0}};
            mid_cnt_r <= {`DIT_PRE_W{1'b0}};
            slow_cnt_r <= {`DIT_PRE_W{1'b0}};
            tick_fast_o <= 1'b0;
            tick_mid_o <= 1'b0;
            tick_slow_o <= 1'b0;
        end else if (ce_i) begin
            tick_fast_o <= wrap(fast_cnt_r, `DIT_DIV_FAST);
            tick_mid_o <= wrap(mid_cnt_r, `DIT_DIV_MID);
            tick_slow_o <= wrap(slow_cnt_r, `DIT_DIV_SLOW);
            fast_cnt_r <= wrap(fast_cnt_r, `DIT_DIV_FAST) ? {`DIT_PRE_W{1'b0}} :
                fast_cnt_r + 1'b1;
            mid_cnt_r <= wrap(mid_cnt_r, `DIT_DIV_MID) ? {`DIT_PRE_W{1'b0}} :
                mid_cnt_r + 1'b1;
            slow_cnt_r <= wrap(slow_cnt_r, `DIT_DIV_SLOW) ? {`DIT_PRE_W{1'b0}} :
                slow_cnt_r + 1'b1;
        end
    end

endmodule // dit_prescaler

// ### dv/dit_timer_properties.sv
// assertion checker watching the dual interval / one-shot timer ports
`timescale 1ns/1ps
module dit_timer_chk (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire reg_req_i,
    input wire reg_we_i,
    input wire [2:0] reg_addr_i,
    input wire reg_bit_i,
    input wire [3:0] reg_bitpos_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_ack_o,
    input wire [15:0] reg_rdata_o,
    input wire timer_wave_out_o,
    input wire t0_irq_flag_o,
    input wire t1_irq_flag_o,
    input wire modulo0_done_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    reg busy_r;
    reg [2:0] n_r;
    reg wr0_r;
    reg [7:0] wd_r;
    reg [7:0] ctl_r;
    wire last = busy_r && ce_i && n_r == 3'h6;
    // shadow of byte writes to t0_ctrl; run bits are cleared by hardware, so only bits 3:0 used
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            n_r <= 3'h0;
            wr0_r <= 1'b0;
            wd_r <= 8'h00;
            ctl_r <= 8'h00;
        end else if (ce_i && !busy_r && reg_req_i) begin
            busy_r <= 1'b1;
            n_r <= 3'h1;
            wr0_r <= reg_we_i && !reg_bit_i && reg_addr_i == 3'h0;
            wd_r <= reg_wdata_i[7:0];
        end else if (last) begin
            busy_r <= 1'b0;
            if (wr0_r)
                ctl_r <= wd_r;
        end else if (busy_r && ce_i) begin
            n_r <= n_r + 3'h1;
        end
    end
    property p_ack_time;
        last |=> reg_ack_o;
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("late ack");
    property p_ack_cause;
        reg_ack_o |-> $past(last);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_rdata_hold;
        $changed(reg_rdata_o) |-> reg_ack_o;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    property p_wave_toggle;
        ctl_r[3] && $past(ctl_r[3]) && t0_irq_flag_o |-> timer_wave_out_o != $past(timer_wave_out_o);
    endproperty
    a_wave_toggle: assert property (p_wave_toggle) else $error("no toggle");
    property p_wave_hold;
        ctl_r[3] && $past(ctl_r[3]) && !t0_irq_flag_o |-> $stable(timer_wave_out_o);
    endproperty
    a_wave_hold: assert property (p_wave_hold) else $error("wave moved");
    property p_wave_idle;
        (ctl_r[1:0] == 2'b00 && !ctl_r[3] && $stable(ctl_r))[*2] |-> timer_wave_out_o == ctl_r[2];
    endproperty
    a_wave_idle: assert property (p_wave_idle) else $error("idle level");
    property p_os_end;
        ctl_r[1:0] == 2'b01 && !ctl_r[3] && t0_irq_flag_o |-> timer_wave_out_o == ctl_r[2];
    endproperty
    a_os_end: assert property (p_os_end) else $error("one-shot end level");
    property p_mod_quiet;
        (ctl_r[1:0] != 2'b01)[*3] |-> !modulo0_done_o;
    endproperty
    a_mod_quiet: assert property (p_mod_quiet) else $error("modulo done in interval");
    c_sq: cover property (ctl_r[3] && t0_irq_flag_o);
    c_mod: cover property (modulo0_done_o);
    c_t1: cover property (t1_irq_flag_o);
endmodule // dit_timer_chk

// ### dv/tb_top.sv
// self-checking bench for the dual interval / one-shot timer
`timescale 1ns/1ps
module tb_top;
    reg core_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg ce_i = 1'b1;
    reg reg_req_i = 1'b0;
    reg reg_we_i = 1'b0;
    reg [2:0] reg_addr_i = 3'h0;
    reg reg_bit_i = 1'b0;
    reg [3:0] reg_bitpos_i = 4'h0;
    reg [15:0] reg_wdata_i = 16'h0000;
    wire reg_ack_o, timer_wave_out_o, t0_irq_flag_o, t1_irq_flag_o, modulo0_done_o;
    wire [15:0] reg_rdata_o;
    wire [2:0] fl = {modulo0_done_o, t1_irq_flag_o, t0_irq_flag_o};
    integer error_cnt = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer tf, a, i;
    reg tw, w1;
    reg [15:0] rd, m;
    reg [16:0] e;
    reg [16:0] q_exp[$]; // bit 16 marks a read whose data is compared
    always #4 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) cyc <= cyc + 1;
    dit_timer u_dit_timer (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .reg_req_i(reg_req_i), .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i),
        .reg_bit_i(reg_bit_i), .reg_bitpos_i(reg_bitpos_i), .reg_wdata_i(reg_wdata_i),
        .reg_ack_o(reg_ack_o), .reg_rdata_o(reg_rdata_o), .timer_wave_out_o(timer_wave_out_o),
        .t0_irq_flag_o(t0_irq_flag_o), .t1_irq_flag_o(t1_irq_flag_o),
        .modulo0_done_o(modulo0_done_o));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("FAIL at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task miss;
        begin
            error_cnt = error_cnt + 1;
            $display("FAIL at %0t: wait ran out", $time);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // register answers are compared here, oldest note first; ack stands across this edge
    always @(negedge core_clk_i) begin
        if (reg_ack_o === 1'b1) begin
            e = q_exp.pop_front();
            if (e[16]) chk(reg_rdata_o, e[15:0]);
        end
    end
    // request held until ack shows, dropped before the next edge so it is not taken again
    task acc(input we, input [2:0] ad, input b, input [3:0] p, input [15:0] d, input [16:0] x);
        integer k;
        begin
            q_exp.push_back(x);
            @(posedge core_clk_i);
            #1;
            reg_req_i = 1'b1;
            reg_we_i = we;
            reg_addr_i = ad;
            reg_bit_i = b;
            reg_bitpos_i = p;
            reg_wdata_i = d;
            k = 0;
            while (reg_ack_o !== 1'b1 && k < 20) begin
                @(posedge core_clk_i);
                #1;
                k = k + 1;
            end
            reg_req_i = 1'b0;
            rd = reg_rdata_o;
            if (k == 20) miss;
        end
    endtask
    task wr(input [2:0] ad, input [15:0] d);
        acc(1'b1, ad, 1'b0, 4'h0, d, 17'h00000);
    endtask
    task rdx(input [2:0] ad, input [15:0] x);
        acc(1'b0, ad, 1'b0, 4'h0, 16'h0000, {1'b1, x});
    endtask
    task wfl(input [1:0] w, input integer lim);
        integer k;
        begin
            k = 0;
            while (fl[w] !== 1'b1 && k < lim) begin
                @(posedge core_clk_i);
                #1;
                k = k + 1;
            end
            tf = cyc;
            tw = timer_wave_out_o;
            if (k == lim) miss;
            @(posedge core_clk_i);
            #1;
        end
    endtask
    initial begin
        i = $urandom(79228);
        repeat (8) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        for (i = 0; i < 6; i = i + 1)
            rdx(i[2:0], 16'h0000);
        for (i = 0; i < 3; i = i + 1) begin
            m = $urandom;
            wr(3'h1, m);
            rdx(3'h1, {8'h00, m[7:6], 6'h00});
        end
        wr(3'h1, 16'h0000);
        for (i = 2; i < 6; i = i + 1) begin
            m = $urandom;
            wr(i[2:0], m);
            rdx(i[2:0], m);
        end
        wr(3'h6, 16'hFFFF);
        rdx(3'h6, 16'h0000);
        acc(1'b1, 3'h1, 1'b1, 4'h6, 16'h0001, 17'h00000);
        acc(1'b1, 3'h1, 1'b1, 4'h2, 16'h0001, 17'h00000);
        rdx(3'h1, 16'h0040);
        m = 16'(2 + $urandom % 4);
        wr(3'h5, m);
        wr(3'h1, 16'h0080);
        wfl(1, 100);
        a = tf;
        wfl(1, 100);
        chk(16'(tf - a), 16'((m + 1) * 6));
        a = tf;
        // a clock-enable gap must stretch the period by exactly its length
        ce_i = 1'b0;
        repeat (50) @(posedge core_clk_i);
        #1;
        ce_i = 1'b1;
        wfl(1, 100);
        chk(16'(tf - a), 16'((m + 1) * 6 + 50));
        wr(3'h1, 16'h00C0);
        wfl(1, 900);
        a = tf;
        wfl(1, 900);
        chk(16'(tf - a), 16'((m + 1) * 128));
        wr(3'h1, 16'h0000);
        acc(1'b0, 3'h4, 1'b0, 4'h0, 16'h0000, 17'h00000);
        repeat (200) @(posedge core_clk_i);
        rdx(3'h4, rd);
        rdx(3'h5, m);
        wr(3'h3, m);
        wr(3'h0, 16'h00B8);
        wfl(0, 100);
        a = tf;
        w1 = tw;
        wfl(0, 100);
        chk(16'(tf - a), 16'((m + 1) * 6));
        chk({15'h0000, tw}, {15'h0000, ~w1});
        rdx(3'h3, m);
        wr(3'h0, 16'h0004);
        repeat (2) @(posedge core_clk_i);
        chk({15'h0000, timer_wave_out_o}, 16'h0001);
        wr(3'h3, 16'h0400);
        wr(3'h0, 16'h00C0);
        repeat (600) @(posedge core_clk_i);
        acc(1'b0, 3'h2, 1'b0, 4'h0, 16'h0000, 17'h00000);
        chk(16'(rd < 16'h03FD), 16'h0001);
        wr(3'h0, 16'h00C0);
        acc(1'b0, 3'h2, 1'b0, 4'h0, 16'h0000, 17'h00000);
        chk(16'(rd >= 16'h03FF), 16'h0001);
        wr(3'h0, 16'h0000);
        wr(3'h2, 16'h0003);
        wr(3'h3, 16'h0005);
        wr(3'h0, 16'h00A1);
        chk({15'h0000, timer_wave_out_o}, 16'h0001);
        wfl(0, 100);
        a = tf;
        w1 = tw;
        wfl(2, 100);
        chk(16'(tf - a), 16'd24);
        chk({15'h0000, w1}, 16'h0000);
        rdx(3'h0, 16'h0001);
        rdx(3'h2, 16'h0000);
        rdx(3'h3, 16'h0000);
        wr(3'h2, 16'h0002);
        wr(3'h3, 16'h0003);
        wr(3'h0, 16'h00F5);
        chk({15'h0000, timer_wave_out_o}, 16'h0000);
        wfl(0, 400);
        a = tf;
        w1 = tw;
        wfl(2, 300);
        chk(16'(tf - a), 16'd128);
        chk({15'h0000, w1}, 16'h0001);
        wr(3'h2, 16'h0100);
        wr(3'h0, 16'h0081);
        repeat (100) @(posedge core_clk_i);
        wr(3'h0, 16'h0001);
        acc(1'b0, 3'h2, 1'b0, 4'h0, 16'h0000, 17'h00000);
        repeat (100) @(posedge core_clk_i);
        rdx(3'h2, rd);
        close_out;
    end
    // the run needs about 4000 cycles; the 50000-cycle limit leaves ample margin
    initial begin
        #400000;
        miss;
        close_out;
    end
endmodule // tb_top
bind dit_timer dit_timer_chk u_dit_timer_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .reg_req_i(reg_req_i), .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i),
    .reg_bit_i(reg_bit_i), .reg_bitpos_i(reg_bitpos_i), .reg_wdata_i(reg_wdata_i),
    .reg_ack_o(reg_ack_o), .reg_rdata_o(reg_rdata_o), .timer_wave_out_o(timer_wave_out_o),
    .t0_irq_flag_o(t0_irq_flag_o), .t1_irq_flag_o(t1_irq_flag_o),
    .modulo0_done_o(modulo0_done_o));
